// [hw/bhl_regs.svh]
`ifndef BHL_REGS_SVH
`define BHL_REGS_SVH
`define BHL_OP_SYNC 6'h13
`define BHL_XO_SYNC 10'h096
`define BHL_OP_X 6'h1f
`define BHL_XO_LBX 10'h057
`define BHL_XO_LBXU 10'h077
`define BHL_OP_LB 6'h22
`define BHL_OP_LBU 6'h23
`define BHL_OP_LH 6'h2a
`define BHL_OP_LHU 6'h2b
`define BHL_ZERO5 5'h00
`define BHL_ZERO32 32'h0000_0000
`define BHL_OP_HI 31
`define BHL_OP_LO 26
`define BHL_RD_HI 25
`define BHL_RD_LO 21
`define BHL_RA_HI 20
`define BHL_RA_LO 16
`define BHL_RB_HI 15
`define BHL_RB_LO 11
`define BHL_XO_HI 10
`define BHL_XO_LO 1
`define BHL_IMM_HI 15
`define BHL_IMM_LO 0
`endif

// [hw/bhl_pkg.sv]
package bhl_pkg;
   typedef enum logic [1:0] {BHL_SZ_BYTE, BHL_SZ_HALF} bhl_size_t;
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic half;
   } bhl_mreq_t;
   typedef struct packed {
      logic valid;
      logic [31:0] data;
      logic no_access;
      logic tlb_miss;
   } bhl_mrsp_t;
   typedef struct packed {
      logic valid;
      logic [4:0] idx;
      logic [31:0] data;
   } bhl_wb_t;
   typedef struct packed {
      logic valid;
      logic storage;
      logic tlb_miss;
      logic [31:0] addr;
   } bhl_exc_t;
endpackage : bhl_pkg

// [hw/bhl_decoder.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bhl_regs.svh"
// Overview of operation
// RULE_01: Sync waits for all earlier instructions.
// RULE_02: Sync flushes prefetch, stalls later instructions.
// RULE_03: Sync does not wait for memory.
// RULE_04: Sync touches no cache, register, exception.
// RULE_05: Reserved bits set give undefined, no trap.
// RULE_06: Displacement sign-extended to 32 bits.
// RULE_07: Base field zero means base zero. Update forms read the register instead.
// RULE_08: Indexed address is base plus index register.
// RULE_09: Update forms use and rewrite base register.
// RULE_10: Byte loads zero-fill upper 24 bits.
// RULE_11: Halfword algebraic loads sign-extend.
// RULE_12: Opcodes 34, 35 decode byte loads.
// RULE_13: Opcodes 42, 43 decode halfword loads.
// RULE_14: Opcode 31 with 87, 119 indexed.
// RULE_15: No-access zone in user relocated raises storage.
// RULE_16: Relocated translation miss raises miss exception.
// RULE_17: Address add is modulo 32 bits.
module bhl_decoder
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_insn_valid,
   input wire logic [31:0] i_insn,
   input wire logic [31:0] i_gpr_a,
   input wire logic [31:0] i_gpr_b,
   input wire logic i_older_busy,
   input wire logic i_user_mode,
   input wire logic i_data_reloc,
   input wire bhl_pkg::bhl_mrsp_t i_mrsp,
   output logic o_insn_ready,
   output logic o_flush,
   output logic o_unknown,
   output bhl_pkg::bhl_mreq_t o_mreq,
   output bhl_pkg::bhl_wb_t o_wb_d,
   output bhl_pkg::bhl_wb_t o_wb_a,
   output bhl_pkg::bhl_exc_t o_exc
);
   import bhl_pkg::*;

   // ****************************************
   // Field decode
   // ****************************************
   typedef enum {ST_IDLE, ST_SYNC, ST_LOAD} bhl_state_t;
   bhl_state_t state;
   bhl_state_t next_state;
   wire [5:0] op = i_insn[`BHL_OP_HI:`BHL_OP_LO];
   wire [9:0] xo = i_insn[`BHL_XO_HI:`BHL_XO_LO];
   wire [4:0] rd_f = i_insn[`BHL_RD_HI:`BHL_RD_LO];
   wire [4:0] base_register_field = i_insn[`BHL_RA_HI:`BHL_RA_LO];
   wire [4:0] index_gpr_field = i_insn[`BHL_RB_HI:`BHL_RB_LO];
   wire [15:0] imm = i_insn[`BHL_IMM_HI:`BHL_IMM_LO];
   // RULE_05: reserved bits ignored, no trap
   // RULE_12: byte displacement forms
   wire is_lb = (op == `BHL_OP_LB);
   wire is_lbu = (op == `BHL_OP_LBU);
   // RULE_13: halfword algebraic forms
   wire is_lh = (op == `BHL_OP_LH);
   wire is_lhu = (op == `BHL_OP_LHU);
   // RULE_14: indexed byte forms
   wire is_lbx = (op == `BHL_OP_X) && (xo == `BHL_XO_LBX);
   wire load_byte_zero_ext_update_indexed = (op == `BHL_OP_X) && (xo == `BHL_XO_LBXU);
   wire is_sync = (op == `BHL_OP_SYNC) && (xo == `BHL_XO_SYNC);
   wire is_upd = is_lbu | is_lhu | load_byte_zero_ext_update_indexed;
   wire is_idx = is_lbx | load_byte_zero_ext_update_indexed;
   wire is_half = is_lh | is_lhu;
   wire is_load = is_lb | is_lbu | is_lh | is_lhu | is_idx;

   // ****************************************
   // Effective address
   // ****************************************
   // RULE_06: sign-extend displacement
   wire [31:0] disp = {{16{imm[15]}}, imm};
   // RULE_07: field zero gives zero base, except in update forms
   // RULE_09: update forms always read the register
   wire base_zero = (base_register_field == `BHL_ZERO5) && !is_upd;
   wire [31:0] base = base_zero ? `BHL_ZERO32 : i_gpr_a;
   // RULE_08: index register as offset
   wire [31:0] offs = is_idx ? i_gpr_b : disp;
   // RULE_17: carry out dropped
   wire [32:0] sum = {1'b0, base} + {1'b0, offs};
   wire [31:0] effective_address = sum[31:0];

   // ****************************************
   // Returned data
   // ****************************************
   // RULE_10: zero-fill byte
   wire [31:0] byte_val = {24'h00_0000, i_mrsp.data[7:0]};
   // RULE_11: sign-extend halfword
   wire [31:0] half_val = {{16{i_mrsp.data[15]}}, i_mrsp.data[15:0]};
   // RULE_15: storage fault only user and relocated
   wire exc_st = i_mrsp.no_access && i_user_mode && i_data_reloc;
   // RULE_16: miss only when relocated
   wire exc_tm = i_mrsp.tlb_miss && i_data_reloc;
   wire rsp_fault = exc_st | exc_tm;
   wire take = i_insn_valid && o_insn_ready;

   logic half_q;
   logic upd_q;
   logic [4:0] rd_q;
   logic [4:0] ra_q;
   logic [31:0] ea_q;

   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (take && is_sync)
               next_state = ST_SYNC;
            else if (take && is_load)
               next_state = ST_LOAD;
         end
         // RULE_01: hold until older work done
         // RULE_03: memory traffic is not awaited
         ST_SYNC:
         begin
            if (!i_older_busy)
               next_state = ST_IDLE;
         end
         ST_LOAD:
         begin
            if (i_mrsp.valid)
               next_state = ST_IDLE;
         end
         default:
            next_state = ST_IDLE;
      endcase
   end

   // ****************************************
   // Next values
   // ****************************************
   wire load_take = take && is_load;
   wire load_done = (state == ST_LOAD) && i_mrsp.valid;
   // RULE_02: no new start until sync done
   wire next_insn_ready = (next_state == ST_IDLE);
   // RULE_02: drop prefetched stream on sync end
   wire next_flush = (state == ST_SYNC) && (next_state == ST_IDLE);
   // A hint for the issue stage, never a trap
   wire next_unknown = take && !is_sync && !is_load;
   // Request stands until answered, so memory may stall freely
   wire next_mreq_valid = load_take || (o_mreq.valid && !i_mrsp.valid);
   wire [31:0] next_mreq_addr = load_take ? effective_address : o_mreq.addr;
   wire next_mreq_half = load_take ? is_half : o_mreq.half;
   // RULE_04: sync issues no write or trap
   wire next_wb_d_valid = load_done && !rsp_fault;
   // RULE_09: write address back to base
   wire next_wb_a_valid = next_wb_d_valid && upd_q;
   wire next_exc_valid = load_done && rsp_fault;
   wire [31:0] next_wb_data = half_q ? half_val : byte_val;
   wire bhl_mreq_t next_mreq = {next_mreq_valid, next_mreq_addr, next_mreq_half};
   wire bhl_wb_t next_wb_d = {next_wb_d_valid, rd_q, next_wb_data};
   wire bhl_wb_t next_wb_a = {next_wb_a_valid, ra_q, ea_q};
   wire bhl_exc_t next_exc = {next_exc_valid, exc_st, exc_tm, ea_q};

   // ****************************************
   // Sequencing
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_insn_ready <= 1'b0;
      else
         o_insn_ready <= next_insn_ready;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_flush <= 1'b0;
      else
         o_flush <= next_flush;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_unknown <= 1'b0;
      else
         o_unknown <= next_unknown;
   end

   // ****************************************
   // Captured instruction
   // ****************************************
   // Kept for the whole load, the offered word may move on
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         half_q <= 1'b0;
      else if (load_take)
         half_q <= is_half;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         upd_q <= 1'b0;
      else if (load_take)
         upd_q <= is_upd;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         rd_q <= `BHL_ZERO5;
      else if (load_take)
         rd_q <= rd_f;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         ra_q <= `BHL_ZERO5;
      else if (load_take)
         ra_q <= base_register_field;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         ea_q <= `BHL_ZERO32;
      else if (load_take)
         ea_q <= effective_address;
   end

   // ****************************************
   // Memory request and results
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_mreq <= '0;
      else
         o_mreq <= next_mreq;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_wb_d <= '0;
      else
         o_wb_d <= next_wb_d;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_wb_a <= '0;
      else
         o_wb_a <= next_wb_a;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_exc <= '0;
      else
         o_exc <= next_exc;
   end
endmodule : bhl_decoder
`default_nettype wire

// [test/bhl_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bhl_mem_model
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire bhl_pkg::bhl_mreq_t i_mreq,
   input wire logic [3:0] i_wait,
   input wire logic [1:0] i_fault,
   output bhl_pkg::bhl_mrsp_t o_mrsp
);
   import bhl_pkg::*;
   // ********
   // Memory reply
   // ********
   logic [3:0] cnt;
   logic done;
   // Data flips between replies so a late sample is never lucky
   always_ff @(posedge i_mclk or posedge i_rst)
      if (i_rst)
      begin
         {cnt, done, o_mrsp} <= '0;
      end
      else if (i_mreq.valid && !done && cnt == i_wait)
      begin
         o_mrsp <= {1'b1, 16'h5a5a, i_mreq.addr[15:0], i_fault};
         {cnt, done} <= 5'h01;
      end
      else
      begin
         o_mrsp <= {1'b0, ~o_mrsp.data, 2'h0};
         done <= done && i_mreq.valid;
         cnt <= (i_mreq.valid && !done) ? cnt + 4'h1 : 4'h0;
      end
endmodule : bhl_mem_model
`default_nettype wire

// [test/bhl_decoder_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module bhl_decoder_monitor
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_insn_valid,
   input wire logic [31:0] i_insn,
   input wire logic [31:0] i_gpr_a,
   input wire logic [31:0] i_gpr_b,
   input wire logic i_older_busy,
   input wire logic i_user_mode,
   input wire logic i_data_reloc,
   input wire bhl_pkg::bhl_mrsp_t i_mrsp,
   input wire logic o_insn_ready,
   input wire logic o_flush,
   input wire bhl_pkg::bhl_mreq_t o_mreq,
   input wire bhl_pkg::bhl_wb_t o_wb_d,
   input wire bhl_pkg::bhl_wb_t o_wb_a,
   input wire bhl_pkg::bhl_exc_t o_exc
);
   import bhl_pkg::*;
   // ********
   // Reference decode
   // ********
   wire [5:0] op = i_insn[31:26];
   wire [9:0] xo = i_insn[10:1];
   wire ix = op == 6'h1f && (xo == 10'h057 || xo == 10'h077);
   wire tk = i_insn_valid && o_insn_ready;
   wire ld = ix || op[5:4] == 2'h2 && op[2:1] == 2'h1;
   wire up = ix ? xo[5] : op[0];
   wire sy = op == 6'h13 && xo == 10'h096;
   wire [31:0] ea = (i_insn[20:16] == 5'h00 && !up ? 32'h0 : i_gpr_a)
      + (ix ? i_gpr_b : {{16{i_insn[15]}}, i_insn[15:0]});
   logic [31:0] ea_q;
   logic [15:0] rd_q;
   logic hf_q, up_q;
   always_ff @(posedge i_mclk)
      if (tk)
         {ea_q, hf_q, up_q} <= {ea, !ix && op[3], up};
   always_ff @(posedge i_mclk)
      if (i_mrsp.valid)
         rd_q <= i_mrsp.data[15:0];
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   a_load_addr: assert property (
      tk && ld |=> o_mreq.valid && o_mreq.addr == ea_q && o_mreq.half == hf_q) else $error("addr");
   a_byte_zero: assert property (
      o_wb_d.valid && !hf_q |-> o_wb_d.data == {24'h0, rd_q[7:0]}) else $error("byte");
   a_half_sext: assert property (
      o_wb_d.valid && hf_q |-> o_wb_d.data == {{16{rd_q[15]}}, rd_q}) else $error("half");
   a_base_write: assert property (
      o_wb_d.valid |-> o_wb_a.valid == up_q && (!up_q || o_wb_a.data == ea_q)) else $error("base");
   a_sync_ends: assert property (
      tk && sy ##1 !i_older_busy [*2] |-> ##[0:3] o_flush) else $error("sync");
   a_sync_waits: assert property (
      o_flush |-> !$past(i_older_busy) && o_insn_ready) else $error("flush");
   a_storage_exc: assert property (
      i_mrsp.valid && i_mrsp.no_access && !i_mrsp.tlb_miss && i_user_mode && i_data_reloc
      |=> o_exc.valid && o_exc.storage && !o_wb_d.valid) else $error("storage");
   a_miss_exc: assert property (
      i_mrsp.valid && i_mrsp.tlb_miss && i_data_reloc |=> o_exc.valid && o_exc.tlb_miss)
      else $error("miss");
endmodule : bhl_decoder_monitor
bind bhl_decoder bhl_decoder_monitor mon (.i_mclk, .i_rst, .i_insn_valid, .i_insn, .i_gpr_a,
   .i_gpr_b, .i_older_busy, .i_user_mode, .i_data_reloc, .i_mrsp, .o_insn_ready, .o_flush,
   .o_mreq, .o_wb_d, .o_wb_a, .o_exc);
`default_nettype wire

// [test/bhl_decoder_test.sv]
`timescale 1ns/100ps
`default_nettype none
module bhl_decoder_test;
   import bhl_pkg::*;
   logic i_mclk, i_rst, i_insn_valid, i_older_busy, i_user_mode, i_data_reloc;
   logic o_insn_ready, o_flush, o_unknown;
   logic [31:0] i_insn, i_gpr_a, i_gpr_b;
   logic [3:0] mw;
   logic [1:0] mf;
   bhl_mrsp_t i_mrsp;
   bhl_mreq_t o_mreq;
   bhl_wb_t o_wb_d, o_wb_a;
   bhl_exc_t o_exc;
   int miscompares, n_tests;
   bhl_decoder uut (.i_mclk, .i_rst, .i_insn_valid, .i_insn, .i_gpr_a, .i_gpr_b, .i_older_busy,
      .i_user_mode, .i_data_reloc, .i_mrsp, .o_insn_ready, .o_flush, .o_unknown, .o_mreq,
      .o_wb_d, .o_wb_a, .o_exc);
   bhl_mem_model mem (.i_mclk, .i_rst, .i_mreq(o_mreq), .i_wait(mw), .i_fault(mf),
      .o_mrsp(i_mrsp));
   // ********
   // Bench tasks
   // ********
   initial
   begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   task chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task tally_and_finish;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   // Request held until the edge that takes it
   task issue(input logic [31:0] w, a, b);
      @(posedge i_mclk);
      #1 {i_insn, i_gpr_a, i_gpr_b, i_insn_valid} = {w, a, b, 1'b1};
      while (o_insn_ready !== 1'b1)
         @(negedge i_mclk);
      @(posedge i_mclk);
      #1 i_insn_valid = 0;
   endtask : issue
   task wres;
      repeat (30)
      begin
         @(negedge i_mclk);
         if (o_wb_d.valid | o_exc.valid | o_flush)
            break;
      end
   endtask : wres
   task t_load(input logic [5:0] op, input logic [9:0] xo, input logic [4:0] ra,
      input logic [15:0] d, input logic [31:0] a, b);
      logic x, u, h;
      logic [31:0] ea;
      x = op == 6'h1f;
      u = x ? xo[5] : op[0];
      h = !x && op[3];
      ea = (ra == 5'h00 && !u ? 32'h0 : a) + (x ? b : {{16{d[15]}}, d});
      issue({op, 5'h03, ra, x ? {5'h04, xo, 1'b0} : d}, a, b);
      repeat (2) @(negedge i_mclk);
      chk(o_mreq.addr, ea);
      chk(o_mreq.half, h);
      wres;
      chk({o_wb_d.valid, o_wb_d.idx}, 6'h23);
      chk(o_wb_d.data, h ? {{16{ea[15]}}, ea[15:0]} : {24'h0, ea[7:0]});
      chk(o_wb_a.valid, u);
      if (u) chk(o_wb_a.data, ea);
      if (u) chk(o_wb_a.idx, ra);
   endtask : t_load
   task t_loads;
      t_load(6'h22, 10'h0, 5'h00, 16'h8004, 32'h1234_0000, 32'h0);
      t_load(6'h23, 10'h0, 5'h05, 16'hfffe, 32'h0000_9001, 32'h0);
      mw = 4'h3;
      t_load(6'h2a, 10'h0, 5'h02, 16'h0010, 32'h0000_8000, 32'h0);
      t_load(6'h2b, 10'h0, 5'h02, 16'h8000, 32'h0001_7000, 32'h0);
      mw = 4'h0;
      t_load(6'h1f, 10'h057, 5'h00, 16'h0, 32'hdead_beef, 32'h0000_00f8);
      t_load(6'h1f, 10'h077, 5'h07, 16'h0, 32'hffff_ff00, 32'h0000_8180);
   endtask : t_loads
   task t_sync(input logic [31:0] w, input logic busy);
      @(posedge i_mclk);
      #1 i_older_busy = busy;
      issue(w, 32'h0, 32'h0);
      repeat (busy ? 4 : 0)
      begin
         @(negedge i_mclk);
         chk(o_flush | o_insn_ready, 32'h0);
      end
      @(posedge i_mclk);
      #1 i_older_busy = 0;
      wres;
      chk({o_flush, o_insn_ready, o_wb_d.valid, o_mreq.valid}, 4'hc);
   endtask : t_sync
   task t_fault;
      logic [7:0] c [4];
      c = '{8'hbc, 8'h5a, 8'h91, 8'h41};
      foreach (c[i])
      begin
         @(posedge i_mclk);
         #1 {mf, i_user_mode, i_data_reloc} = c[i][7:4];
         issue({6'h22, 10'h060, 16'h0010}, 32'h0, 32'h0);
         wres;
         chk({o_exc.valid, o_exc.storage, o_exc.tlb_miss, o_wb_d.valid}, c[i][3:0]);
         chk(o_exc.addr, 32'h0000_0010);
      end
      @(posedge i_mclk);
      #1 {mf, i_user_mode, i_data_reloc} = 4'h0;
   endtask : t_fault
   // Words outside the handled family must not start a load
   task t_unknown(input logic [31:0] w);
      issue(w, 32'h0, 32'h0);
      @(negedge i_mclk);
      chk({o_unknown, o_insn_ready, o_mreq.valid}, 3'h6);
   endtask : t_unknown
   initial
   begin
      {i_rst, i_insn_valid, i_insn, i_gpr_a, i_gpr_b, mw, mf} = {1'b1, 103'h0};
      {i_older_busy, i_user_mode, i_data_reloc, miscompares, n_tests} = '0;
      repeat (8) @(posedge i_mclk);
      #1 i_rst = 0;
      t_loads;
      t_sync({6'h13, 15'h0, 10'h096, 1'b0}, 1'b1);
      t_sync({6'h13, 15'h0, 10'h096, 1'b1}, 1'b0);
      t_fault;
      t_unknown({6'h1f, 5'h03, 5'h00, 5'h04, 10'h157, 1'b0});
      t_unknown({6'h28, 5'h03, 5'h00, 16'h0010});
      tally_and_finish;
   end
   initial
   begin
      #20us;
      miscompares++;
      tally_and_finish;
   end
endmodule : bhl_decoder_test
`default_nettype wire
